// >>> pin_bank_cfg.svh
// Offsets, reset values and widths for the pin bank controller
`ifndef PIN_BANK_CFG_SVH
`define PIN_BANK_CFG_SVH

`define PIN_COUNT         16
`define ADDR_WIDTH        10
`define DATA_WIDTH        16

`define OFS_OWNER_SELECT  10'h3c0
`define OFS_DIRECTION     10'h3c1
`define OFS_OUTPUT_SET    10'h3c2
`define OFS_OUTPUT_CLEAR  10'h3c3
`define OFS_LEVEL         10'h3c4
`define OFS_HIGH_IMP      10'h3c5
`define OFS_DRIVE_TYPE    10'h3c6
`define OFS_PULLUP_EN     10'h3c7
`define OFS_PULLDOWN_EN   10'h3c8

`define RST_OWNER_SELECT  16'h0000
`define RST_DIRECTION     16'h0000
`define RST_LEVEL         16'h0000
`define RST_HIGH_IMP      16'h0000
`define RST_DRIVE_TYPE    16'h0000
`define RST_PULLUP_EN     16'hffff
`define RST_PULLDOWN_EN   16'h0000
`define RST_READ_DATA     16'h0000

`endif

// >>> pin_bank_pkg.sv
// Types shared by the pin bank controller files
`include "pin_bank_cfg.svh"

package pin_bank_pkg;

  typedef logic [`PIN_COUNT-1:0]  pin_vec_t;
  typedef logic [`ADDR_WIDTH-1:0] reg_addr_t;
  typedef logic [`DATA_WIDTH-1:0] reg_data_t;

  typedef enum logic [3:0] {
    SEL_NONE         = 4'h0,
    SEL_OWNER_SELECT = 4'h1,
    SEL_DIRECTION    = 4'h2,
    SEL_OUTPUT_SET   = 4'h3,
    SEL_OUTPUT_CLEAR = 4'h4,
    SEL_LEVEL        = 4'h5,
    SEL_HIGH_IMP     = 4'h6,
    SEL_DRIVE_TYPE   = 4'h7,
    SEL_PULLUP_EN    = 4'h8,
    SEL_PULLDOWN_EN  = 4'h9
  } reg_sel_t;

  typedef struct packed {
    pin_vec_t  owner;
    pin_vec_t  dir;
    pin_vec_t  out_val;
    pin_vec_t  high_imp;
    pin_vec_t  open_drain;
    pin_vec_t  pull_up;
    pin_vec_t  pull_dn;
    reg_data_t rdata;
    logic      rvalid;
    pin_vec_t  pad_out;
    pin_vec_t  pad_oe_n;
    pin_vec_t  pad_pu;
    pin_vec_t  pad_pd;
    pin_vec_t  uart_in;
  } ctrl_state_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  // Address to register select
  function automatic reg_sel_t decode_addr(input reg_addr_t addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      `OFS_OWNER_SELECT: sel = SEL_OWNER_SELECT;
      `OFS_DIRECTION:    sel = SEL_DIRECTION;
      `OFS_OUTPUT_SET:   sel = SEL_OUTPUT_SET;
      `OFS_OUTPUT_CLEAR: sel = SEL_OUTPUT_CLEAR;
      `OFS_LEVEL:        sel = SEL_LEVEL;
      `OFS_HIGH_IMP:     sel = SEL_HIGH_IMP;
      `OFS_DRIVE_TYPE:   sel = SEL_DRIVE_TYPE;
      `OFS_PULLUP_EN:    sel = SEL_PULLUP_EN;
      `OFS_PULLDOWN_EN:  sel = SEL_PULLDOWN_EN;
      default:           sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // Pins owned by the controller and set as outputs
  function automatic pin_vec_t owned_outputs(input pin_vec_t owner,
                                             input pin_vec_t dir);
    return owner & dir;
  endfunction : owned_outputs

endpackage : pin_bank_pkg

// >>> reset_sync.sv
// Two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ns

module reset_sync (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  output wire logic rst_n_o
);

  pin_bank_pkg::sync_state_t s_r;
  pin_bank_pkg::sync_state_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.stage1 = 1'b1;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rst_n_o = s_r.stage2;

endmodule : reset_sync

// >>> pin_bank_io_controller.sv
// Register file and pad drive logic for the lower bank of 16 pins
`timescale 1ns/1ns
`include "pin_bank_cfg.svh"

module pin_bank_io_controller (
  input  wire logic                       core_clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [`ADDR_WIDTH-1:0]     reg_addr_i,
  input  wire logic [`DATA_WIDTH-1:0]     reg_wdata_i,
  output wire logic [`DATA_WIDTH-1:0]     reg_rdata_o,
  output wire logic                       reg_rvalid_o,
  input  wire logic [`PIN_COUNT-1:0]      pin_in_i,
  output wire logic [`PIN_COUNT-1:0]      pin_out_o,
  output wire logic [`PIN_COUNT-1:0]      pin_oe_n_o,
  output wire logic [`PIN_COUNT-1:0]      pin_pullup_o,
  output wire logic [`PIN_COUNT-1:0]      pin_pulldown_o,
  input  wire logic [`PIN_COUNT-1:0]      uart_pin_out_i,
  input  wire logic [`PIN_COUNT-1:0]      uart_pin_oe_n_i,
  input  wire logic [`PIN_COUNT-1:0]      uart_pin_pullup_i,
  input  wire logic [`PIN_COUNT-1:0]      uart_pin_pulldown_i,
  output wire logic [`PIN_COUNT-1:0]      uart_pin_in_o
);

  localparam pin_bank_pkg::ctrl_state_t RESET_STATE = '{
    owner:      `RST_OWNER_SELECT,
    dir:        `RST_DIRECTION,
    out_val:    `RST_LEVEL,
    high_imp:   `RST_HIGH_IMP,
    open_drain: `RST_DRIVE_TYPE,
    pull_up:    `RST_PULLUP_EN,
    pull_dn:    `RST_PULLDOWN_EN,
    rdata:      `RST_READ_DATA,
    rvalid:     1'b0,
    pad_out:    '0,
    pad_oe_n:   '1,
    pad_pu:     '0,
    pad_pd:     '0,
    uart_in:    '0
  };

  logic                          rst_n;
  pin_bank_pkg::ctrl_state_t     s_r;
  pin_bank_pkg::ctrl_state_t     s_nxt;
  pin_bank_pkg::reg_sel_t        wr_sel;
  pin_bank_pkg::reg_sel_t        rd_sel;
  pin_bank_pkg::pin_vec_t        out_mask;
  pin_bank_pkg::pin_vec_t        wdata;

  reset_sync u_reset_sync (
    .clk_i    (core_clk_i),
    .arst_n_i (arst_n_i),
    .rst_n_o  (rst_n)
  );

  assign wr_sel   = pin_bank_pkg::decode_addr(reg_addr_i);
  assign rd_sel   = pin_bank_pkg::decode_addr(reg_addr_i);
  assign out_mask = pin_bank_pkg::owned_outputs(s_r.owner, s_r.dir);
  assign wdata    = reg_wdata_i;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;

    // Register writes
    if (reg_wr_i) begin
      unique case (wr_sel)
        pin_bank_pkg::SEL_OWNER_SELECT: begin
          s_nxt.owner = wdata;
        end
        pin_bank_pkg::SEL_DIRECTION: begin
          s_nxt.dir = wdata;
        end
        pin_bank_pkg::SEL_OUTPUT_SET: begin
          s_nxt.out_val = s_r.out_val | (wdata & out_mask);
        end
        pin_bank_pkg::SEL_OUTPUT_CLEAR: begin
          s_nxt.out_val = s_r.out_val & ~(wdata & out_mask);
        end
        pin_bank_pkg::SEL_LEVEL: begin
          s_nxt.out_val = (s_r.out_val & ~out_mask) | (wdata & out_mask);
        end
        pin_bank_pkg::SEL_HIGH_IMP: begin
          s_nxt.high_imp = wdata;
        end
        pin_bank_pkg::SEL_DRIVE_TYPE: begin
          s_nxt.open_drain = wdata;
        end
        pin_bank_pkg::SEL_PULLUP_EN: begin
          s_nxt.pull_up = wdata;
        end
        pin_bank_pkg::SEL_PULLDOWN_EN: begin
          s_nxt.pull_dn = wdata;
        end
        pin_bank_pkg::SEL_NONE: begin
          s_nxt.out_val = s_r.out_val;
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (reg_rd_i) begin
      s_nxt.rvalid = 1'b1;
      unique case (rd_sel)
        pin_bank_pkg::SEL_OWNER_SELECT: begin
          s_nxt.rdata = s_r.owner;
        end
        pin_bank_pkg::SEL_DIRECTION: begin
          s_nxt.rdata = s_r.dir;
        end
        pin_bank_pkg::SEL_OUTPUT_SET: begin
          s_nxt.rdata = '0;
        end
        pin_bank_pkg::SEL_OUTPUT_CLEAR: begin
          s_nxt.rdata = '0;
        end
        pin_bank_pkg::SEL_LEVEL: begin
          s_nxt.rdata = pin_in_i & s_r.owner;
        end
        pin_bank_pkg::SEL_HIGH_IMP: begin
          s_nxt.rdata = s_r.high_imp;
        end
        pin_bank_pkg::SEL_DRIVE_TYPE: begin
          s_nxt.rdata = s_r.open_drain;
        end
        pin_bank_pkg::SEL_PULLUP_EN: begin
          s_nxt.rdata = s_r.pull_up;
        end
        pin_bank_pkg::SEL_PULLDOWN_EN: begin
          s_nxt.rdata = s_r.pull_dn;
        end
        pin_bank_pkg::SEL_NONE: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // Pad drive, all pins update on the same edge
    // Aligned update is allowed
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (!s_r.owner[i]) begin
        s_nxt.pad_out[i]  = uart_pin_out_i[i];
        s_nxt.pad_oe_n[i] = uart_pin_oe_n_i[i];
        s_nxt.pad_pu[i]   = uart_pin_pullup_i[i];
        s_nxt.pad_pd[i]   = uart_pin_pulldown_i[i];
        s_nxt.uart_in[i]  = pin_in_i[i];
      end else if (s_r.dir[i]) begin
        s_nxt.uart_in[i]  = 1'b0;
        s_nxt.pad_pd[i]   = 1'b0;
        if (s_r.high_imp[i]) begin
          s_nxt.pad_out[i]  = 1'b0;
          s_nxt.pad_oe_n[i] = 1'b1;
          s_nxt.pad_pu[i]   = s_r.open_drain[i];
        end else if (s_r.open_drain[i]) begin
          s_nxt.pad_out[i]  = 1'b0;
          s_nxt.pad_oe_n[i] = s_r.out_val[i];
          s_nxt.pad_pu[i]   = 1'b1;
        end else begin
          s_nxt.pad_out[i]  = s_r.out_val[i];
          s_nxt.pad_oe_n[i] = 1'b0;
          s_nxt.pad_pu[i]   = 1'b0;
        end
      end else begin
        s_nxt.uart_in[i]  = 1'b0;
        s_nxt.pad_out[i]  = 1'b0;
        s_nxt.pad_oe_n[i] = 1'b1;
        s_nxt.pad_pu[i]   = s_r.pull_up[i];
        s_nxt.pad_pd[i]   = s_r.pull_dn[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o    = s_r.rdata;
  assign reg_rvalid_o   = s_r.rvalid;
  assign pin_out_o      = s_r.pad_out;
  assign pin_oe_n_o     = s_r.pad_oe_n;
  assign pin_pullup_o   = s_r.pad_pu;
  assign pin_pulldown_o = s_r.pad_pd;
  assign uart_pin_in_o  = s_r.uart_in;

endmodule : pin_bank_io_controller

// >>> pin_bank_io_controller_props.sv
// Port checker for the pin bank controller
`timescale 1ns/1ns
module pin_bank_io_controller_props (
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [9:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [15:0] pin_in_i,
  input wire logic [15:0] pin_out_o,
  input wire logic [15:0] pin_oe_n_o,
  input wire logic [15:0] pin_pullup_o,
  input wire logic [15:0] uart_pin_out_i,
  input wire logic [15:0] uart_pin_oe_n_i
);
  logic [3:0]  up_r;
  logic [15:0] own_r, dir_r, od_r, m, wm, wl, iv, od;

  assign m  = own_r & dir_r;
  assign wm = reg_wdata_i & m;
  assign wl = ~reg_wdata_i & m;
  assign iv = own_r & ~dir_r;
  assign od = m & od_r;

  // Shadow of owner, direction and drive type
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_r  <= 4'h0;
      own_r <= 16'h0000;
      dir_r <= 16'h0000;
      od_r  <= 16'h0000;
    end else begin
      up_r <= {up_r[2:0], 1'b1};
      if (reg_wr_i && reg_addr_i == 10'h3c0) own_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 10'h3c1) dir_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 10'h3c6) od_r <= reg_wdata_i;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!up_r[3]);

  property p_rd; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_lvl;
    reg_rd_i && reg_addr_i == 10'h3c4
      |=> reg_rdata_o == ($past(pin_in_i) & $past(own_r));
  endproperty
  a_lvl: assert property (p_lvl) else $error("bad level read");
  property p_wo;
    reg_rd_i && (reg_addr_i inside {10'h3c2, 10'h3c3} || reg_addr_i > 10'h3c8)
      |=> reg_rdata_o == 16'h0000;
  endproperty
  a_wo: assert property (p_wo) else $error("nonzero read");
  property p_set;
    reg_wr_i && reg_addr_i == 10'h3c2
      |-> ##2 ((pin_out_o | pin_oe_n_o) & $past(wm, 2)) == $past(wm, 2);
  endproperty
  a_set: assert property (p_set) else $error("set missed");
  property p_clr;
    reg_wr_i && reg_addr_i == 10'h3c3
      |-> ##2 (pin_out_o & $past(wm, 2)) == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_lw;
    reg_wr_i && reg_addr_i == 10'h3c4 |-> ##2 (pin_out_o & $past(wl, 2))
      == 16'h0000 && ((pin_out_o | pin_oe_n_o) & $past(wm, 2)) == $past(wm, 2);
  endproperty
  a_lw: assert property (p_lw) else $error("level write missed");
  property p_pass;
    (((pin_out_o ^ $past(uart_pin_out_i)) | (pin_oe_n_o
      ^ $past(uart_pin_oe_n_i))) & ~$past(own_r)) == 16'h0000;
  endproperty
  a_pass: assert property (p_pass) else $error("uart path broken");
  property p_inp; (~pin_oe_n_o & $past(iv)) == 16'h0000; endproperty
  a_inp: assert property (p_inp) else $error("input driven");
  property p_od;
    (pin_out_o & $past(od)) == 16'h0000 && (pin_pullup_o & $past(od)) == $past(od);
  endproperty
  a_od: assert property (p_od) else $error("open drain wrong");
  c_lvl: cover property (reg_rd_i && reg_addr_i == 10'h3c4);
  c_clr: cover property (reg_wr_i && reg_addr_i == 10'h3c3);
  c_od: cover property (od != 16'h0000);
endmodule : pin_bank_io_controller_props

bind pin_bank_io_controller pin_bank_io_controller_props props_u (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
  .pin_pullup_o(pin_pullup_o), .uart_pin_out_i(uart_pin_out_i),
  .uart_pin_oe_n_i(uart_pin_oe_n_i)
);

// >>> pin_pad_model.sv
// Pads with pulls and external drivers
`timescale 1ns/1ns
module pin_pad_model (
  input  wire logic [15:0] out_i,
  input  wire logic [15:0] oe_n_i,
  input  wire logic [15:0] pu_i,
  input  wire logic [15:0] pd_i,
  input  wire logic [15:0] ext_en_i,
  input  wire logic [15:0] ext_val_i,
  input  wire logic        clk_i,
  output wire logic [15:0] level_o
);
  logic [15:0] last_r = 16'h0000;

  // Floating pins flip every cycle, unknowns taken as low
  always @(posedge clk_i) begin
    for (int k = 0; k < 16; k++) begin
      last_r[k] <= (level_o[k] === 1'b1);
    end
  end
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_val_i)
    | (oe_n_i & ~ext_en_i & (pu_i | (~pd_i & ~last_r)));
endmodule : pin_pad_model

// >>> pin_bank_io_controller_bench.sv
// Self-checking bench for the pin bank controller
`timescale 1ns/1ns
module pin_bank_io_controller_bench;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        wr_r   = 1'b0;
  logic        rd_r   = 1'b0;
  logic [9:0]  a_r    = 10'h000;
  logic [15:0] d_r    = 16'h0000;
  logic [15:0] xen_r  = 16'hff00;
  logic [15:0] uo_r   = 16'h1234;
  logic [15:0] p_in, p_out, p_oe, p_pu, p_pd, rdata, u_in;
  logic        rvalid;
  int          mismatches = 0;
  int          checked    = 0;
  int          cyc        = 0;

  always #20 clk = ~clk;

  pin_bank_io_controller dut_u (
    .core_clk_i(clk), .arst_n_i(rst_n), .reg_wr_i(wr_r), .reg_rd_i(rd_r),
    .reg_addr_i(a_r), .reg_wdata_i(d_r), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .pin_in_i(p_in), .pin_out_o(p_out),
    .pin_oe_n_o(p_oe), .pin_pullup_o(p_pu), .pin_pulldown_o(p_pd),
    .uart_pin_out_i(uo_r), .uart_pin_oe_n_i(16'h00ff),
    .uart_pin_pullup_i(16'hf0f0), .uart_pin_pulldown_i(16'h0f0f),
    .uart_pin_in_o(u_in)
  );
  pin_pad_model pad_u (
    .out_i(p_out), .oe_n_i(p_oe), .pu_i(p_pu), .pd_i(p_pd),
    .ext_en_i(xen_r), .ext_val_i(16'ha500), .clk_i(clk), .level_o(p_in)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_r <= 1'b1;
    a_r  <= a;
    d_r  <= d;
    @(posedge clk);
    wr_r <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_r <= 1'b1;
    a_r  <= a;
    @(posedge clk);
    rd_r <= 1'b0;
    #1;
    chk({rvalid, rdata}, {1'b1, e});
  endtask : rd

  task automatic pads(input logic [15:0] o, input logic [15:0] n);
    @(posedge clk);
    #1;
    chk({p_out, p_oe}, {o, n});
  endtask : pads

  task automatic wrap_up();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(10'h3c0 + 10'(i), (i == 7) ? 16'hffff : 16'h0000);
    end
    wr(10'h3c1, 16'hffff);
    wr(10'h3c2, 16'hffff);
    pads(16'h1234, 16'h00ff);
    chk({p_pu, p_pd}, 32'hf0f00f0f);
    chk({16'h0000, u_in}, 32'h000012f0);
    wr(10'h3c0, 16'hffff);
    wr(10'h3c1, 16'h00ff);
    wr(10'h3c7, 16'hff00);
    pads(16'h0000, 16'hff00);
    rd(10'h3c0, 16'hffff);
    rd(10'h3c1, 16'h00ff);
    wr(10'h3c2, 16'h0ff3);
    pads(16'h00f3, 16'hff00);
    wr(10'h3c3, 16'hff21);
    pads(16'h00d2, 16'hff00);
    rd(10'h3c4, 16'ha5d2);
    wr(10'h3c4, 16'h5a3c);
    pads(16'h003c, 16'hff00);
    wr(10'h3c5, 16'h0004);
    pads(16'h0038, 16'hff04);
    wr(10'h3c5, 16'h0000);
    wr(10'h3c6, 16'h00f0);
    pads(16'h000c, 16'hff30);
    chk({16'h0000, p_pu}, 32'h0000fff0);
    rd(10'h3c4, 16'ha53c);
    wr(10'h3c7, 16'h0f00);
    xen_r <= 16'h0000;
    wr(10'h3c8, 16'hf000);
    pads(16'h000c, 16'hff30);
    chk({p_pu, p_pd}, 32'h0ff0f000);
    rd(10'h3c4, 16'h0f3c);
    wr(10'h3c0, 16'h00ff);
    pads(16'h120c, 16'h0030);
    @(posedge clk);
    uo_r <= 16'hedcb;
    #1;
    chk({16'h0000, u_in}, 32'h00001200);
    pads(16'hed0c, 16'h0030);
    wrap_up();
  end
endmodule : pin_bank_io_controller_bench
